// *** hdl/irq_latch_pkg.sv ***
package irq_latch_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 5;

  // register addresses on the internal register port
  localparam logic [4:0] SOURCE_ADDR     = 5'h08;
  localparam logic [4:0] LATCH_SET_ADDR  = 5'h0A;
  localparam logic [4:0] LATCH_CLR_ADDR  = 5'h0B;
  localparam logic [4:0] FALL_SET_ADDR   = 5'h0C;
  localparam logic [4:0] FALL_CLR_ADDR   = 5'h0D;
  localparam logic [4:0] RISE_SET_ADDR   = 5'h0E;
  localparam logic [4:0] RISE_CLR_ADDR   = 5'h0F;

  // field positions
  localparam int unsigned VBUS_HIGH_DETECT_BIT  = 0;
  localparam int unsigned SESSION_VALID_BIT     = 1;
  localparam int unsigned DPLUS_HIGH_LEVEL_BIT  = 2;
  localparam int unsigned ID_PIN_GROUNDED_BIT   = 3;
  localparam int unsigned SINGLE_ENDED_ONE_BIT  = 4;
  localparam int unsigned ID_PIN_FLOATING_BIT   = 5;
  localparam int unsigned RESERVED_BIT          = 6;
  localparam int unsigned DPLUS_CARKIT_BIT      = 7;

  // bits that hold state; bit 6 reads zero
  localparam logic [7:0] IMPL_MASK   = 8'hBF;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] FALL_RESET  = 8'h00;
  localparam logic [7:0] RISE_RESET  = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // register port request: one-cycle strobe with address and data
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // seven detector levels, gathered in register bit order
  typedef struct packed {
    logic dplus_carkit_threshold;
    logic id_pin_floating;
    logic single_ended_one;
    logic id_pin_grounded;
    logic dplus_high_level;
    logic session_valid;
    logic vbus_high_detect;
  } detect_s;

endpackage

// *** hdl/edge_latch_bit.sv ***
`timescale 1ns/100ps
// one latch bit: edge events and software set win over software clear
module edge_latch_bit (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic level,
  input  wire logic level_prev,
  input  wire logic fall_en,
  input  wire logic rise_en,
  input  wire logic sw_set,
  input  wire logic sw_clr,
  output logic      latched
);

  logic latched_q;
  logic latched_d;
  logic fell;
  logic rose;

  always_comb begin
    fell      = level_prev & ~level & fall_en;
    rose      = ~level_prev & level & rise_en;
    latched_d = latched_q;
    if (sw_clr) begin
      latched_d = 1'b0;
    end
    // a set event in the clearing cycle is kept
    if (sw_set | fell | rose) begin
      latched_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latched_q <= 1'b0;
    end else begin
      latched_q <= latched_d;
    end
  end

  assign latched = latched_q;

endmodule

// *** hdl/irq_latch.sv ***
`timescale 1ns/100ps
module irq_latch (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire irq_latch_pkg::reg_req_s req,
  input  wire irq_latch_pkg::detect_s  detect,
  output logic [7:0]                 rdata,
  output logic                       rvalid,
  output logic [7:0]                 latch_out
);

  logic [7:0] source;
  logic [7:0] source_q;
  logic [7:0] source_prev_q;
  logic [7:0] fall_q;
  logic [7:0] fall_d;
  logic [7:0] rise_q;
  logic [7:0] rise_d;
  logic [7:0] latch_w;
  logic [7:0] latch_set;
  logic [7:0] latch_clr;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic [7:0] wmask;

  // place detector levels in register bit order, bit 6 fixed low
  always_comb begin
    source = {detect.dplus_carkit_threshold, 1'b0, detect.id_pin_floating, detect.single_ended_one,
              detect.id_pin_grounded, detect.dplus_high_level, detect.session_valid,
              detect.vbus_high_detect};
  end

  always_comb begin
    wmask     = req.wdata & irq_latch_pkg::IMPL_MASK;
    latch_set = (req.wr && req.addr == irq_latch_pkg::LATCH_SET_ADDR) ? wmask : 8'h00;
    latch_clr = (req.wr && req.addr == irq_latch_pkg::LATCH_CLR_ADDR) ? wmask : 8'h00;
    fall_d    = fall_q;
    rise_d    = rise_q;
    if (req.wr) begin
      unique case (req.addr)
        irq_latch_pkg::FALL_SET_ADDR: fall_d = fall_q | wmask;
        irq_latch_pkg::FALL_CLR_ADDR: fall_d = fall_q & ~wmask;
        irq_latch_pkg::RISE_SET_ADDR: rise_d = rise_q | wmask;
        irq_latch_pkg::RISE_CLR_ADDR: rise_d = rise_q & ~wmask;
        default: ;
      endcase
    end
  end

  // edge detection looks at registered levels so both samples share one edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      source_q      <= 8'h00;
      source_prev_q <= 8'h00;
      fall_q        <= irq_latch_pkg::FALL_RESET;
      rise_q        <= irq_latch_pkg::RISE_RESET;
    end else begin
      source_q      <= source;
      source_prev_q <= source_q;
      fall_q        <= fall_d;
      rise_q        <= rise_d;
    end
  end

  // bit 6 has no cell and reads zero
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      if (i == irq_latch_pkg::RESERVED_BIT) begin : g_rsvd
        assign latch_w[i] = 1'b0;
      end else begin : g_cell
        edge_latch_bit u_bit (
          .clk       (clk),
          .resetn    (resetn),
          .level     (source_q[i]),
          .level_prev(source_prev_q[i]),
          .fall_en   (fall_q[i]),
          .rise_en   (rise_q[i]),
          .sw_set    (latch_set[i]),
          .sw_clr    (latch_clr[i]),
          .latched   (latch_w[i])
        );
      end
    end
  endgenerate

  // both addresses of a pair read the same register
  always_comb begin
    rdata_d = rdata_q;
    if (req.rd) begin
      unique case (req.addr)
        irq_latch_pkg::SOURCE_ADDR:    rdata_d = source_q;
        irq_latch_pkg::LATCH_SET_ADDR,
        irq_latch_pkg::LATCH_CLR_ADDR: rdata_d = latch_w;
        irq_latch_pkg::FALL_SET_ADDR,
        irq_latch_pkg::FALL_CLR_ADDR:  rdata_d = fall_q;
        irq_latch_pkg::RISE_SET_ADDR,
        irq_latch_pkg::RISE_CLR_ADDR:  rdata_d = rise_q;
        default:                       rdata_d = irq_latch_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= req.rd;
    end
  end

  assign rdata     = rdata_q;
  assign rvalid    = rvalid_q;
  assign latch_out = latch_w;

endmodule

// *** test/irq_latch_assertions.sv ***
`timescale 1ns/100ps
module irq_latch_assertions (
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire irq_latch_pkg::reg_req_s req,
  input wire irq_latch_pkg::detect_s  detect,
  input wire logic [7:0]              rdata,
  input wire logic                    rvalid,
  input wire logic [7:0]              latch_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_RESV: assert property (latch_out[6] == 1'b0) else $error("reserved bit set");
  AST_RV: assert property (req.rd |=> rvalid) else $error("no rvalid");
  AST_NORV: assert property (!req.rd |=> !rvalid) else $error("stray rvalid");
  AST_SET: assert property (req.wr && req.addr == 5'h0A
    |=> (latch_out & $past(req.wdata) & 8'hBF) == ($past(req.wdata) & 8'hBF)) else $error("set lost");
  AST_HOLD: assert property (!(req.wr && req.addr == 5'h0B)
    |=> ($past(latch_out) & ~latch_out) == 8'h00) else $error("bit fell");
  AST_RDL: assert property (req.rd && req.addr == 5'h0A
    |=> rdata == $past(latch_out)) else $error("latch read");
  AST_UNM: assert property (req.rd && req.addr > 5'h0F |=> rdata == 8'h00) else $error("unmapped");
  AST_RHOLD: assert property (!req.rd |=> $stable(rdata)) else $error("rdata moved");
  // stable detect keeps the sample stage out of the comparison
  AST_SRC: assert property (req.rd && req.addr == 5'h08 && $stable(detect)
    |=> rdata == {$past(detect[6]), 1'b0, $past(detect[5:0])}) else $error("source read");
endmodule
bind irq_latch irq_latch_assertions irq_latch_assertions_inst (.clk(clk), .resetn(resetn), .req(req),
  .detect(detect), .rdata(rdata), .rvalid(rvalid), .latch_out(latch_out));

// *** test/tb_irq_latch.sv ***
`timescale 1ns/100ps
module tb_irq_latch;
  logic                    clk = 1'b0;
  logic                    resetn = 1'b0;
  irq_latch_pkg::reg_req_s req = '0;
  irq_latch_pkg::detect_s  detect = '0;
  logic [7:0]              rdata;
  logic [7:0]              latch_out;
  logic                    rvalid;
  int                      err_count = 0;
  int                      total_checks = 0;
  always #5 clk = ~clk;
  irq_latch irq_latch_inst (.clk(clk), .resetn(resetn), .req(req), .detect(detect), .rdata(rdata),
    .rvalid(rvalid), .latch_out(latch_out));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, e);
  endtask
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic t_regs();
    chk(latch_out, 8'h00);
    rd(5'h0A, 8'h00);
    rd(5'h0C, 8'h00);
    wr(5'h0A, 8'hFF);
    rd(5'h0B, 8'hBF);
    wr(5'h0B, 8'h0F);
    rd(5'h0A, 8'hB0);
    wr(5'h0B, 8'hFF);
    chk(latch_out, 8'h00);
    wr(5'h0C, 8'hFF);
    wr(5'h0D, 8'hFE);
    rd(5'h0D, 8'h01);
    rd(5'h1F, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_edges();
    detect = 7'h7F;
    settle();
    chk(latch_out, 8'h00);
    wr(5'h08, 8'h00);
    rd(5'h08, 8'hBF);
    detect = 7'h7C;
    settle();
    chk(latch_out, 8'h01);
    detect = 7'h78;
    settle();
    chk(latch_out, 8'h01);
    wr(5'h0E, 8'h04);
    detect = 7'h7C;
    settle();
    chk(latch_out, 8'h05);
    rd(5'h0F, 8'h04);
    wr(5'h0F, 8'h04);
    rd(5'h0E, 8'h00);
    rd(5'h03, 8'h00);
    $display("test edges done");
  endtask
  task automatic t_reset();
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    chk(latch_out, 8'h00);
    resetn = 1'b1;
    rd(5'h0C, 8'h00);
    rd(5'h0A, 8'h00);
    $display("test reset done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    t_regs();
    t_edges();
    t_reset();
    close_out();
  end
  initial begin
    #20000;
    err_count++;
    $display("unexpected at %0t: watchdog", $time);
    close_out();
  end
endmodule
